// ==== rtl/core_defs.svh ====
// Purpose: shared constants of the fetch, operand and condition logic
// Assumes: included by bare name from the package and the core
// Notes: opcode and condition codes are plain encodings of this block
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

// word and address widths
`define WORD_W 32
`define ADDR_W 9
`define RAM_DEPTH 512
`define MEM_ADDR_W 16
// load sequence: words copied, then special registers cleared
`define IDX_ZERO 10'h000
`define LOAD_LAST 10'h1ef
`define CLEAR_LAST 10'h1ff
`define IDX_STEP 10'h001
`define WORD_BYTES 16'h0004
// program counter
`define PC_RESET 9'h000
`define PC_STEP 9'h001
// immediate zero extension
`define IMM_PAD 23'h000000
`define WORD_ZERO 32'h00000000
`define WORD_ONE 32'h00000001
// opcodes
`define OP_AND 6'h18
`define OP_OR 6'h1a
`define OP_XOR 6'h1b
`define OP_JMP 6'h17
`define OP_ADD 6'h20
`define OP_SUB 6'h21
`define OP_MOV 6'h28
`define OP_DJNZ 6'h39
// condition codes: bit {c,z} of the code says whether to run
`define COND_NEVER 4'h0
`define COND_ALWAYS 4'hf
`define COND_EQUAL 4'ha
`define COND_ZERO_CLEAR 4'h5
`define COND_ABOVE 4'h1
`define COND_BELOW 4'hc
`define COND_ABOVE_OR_SAME 4'h3

`endif

// ==== rtl/core_pkg.sv ====
// Purpose: types shared by the core and its testbench
// Assumes: core_defs.svh on the include path
// Notes: instruction layout is the packed struct below
`default_nettype none
`include "core_defs.svh"
package core_pkg;
	// one instruction word, msb first
	typedef struct packed {
		logic [5:0] opcode;
		logic wz;
		logic wc;
		logic wr;
		logic imm;
		logic [3:0] cond;
		logic [`ADDR_W-1:0] dst;
		logic [`ADDR_W-1:0] src;
	} instr_t;
	// read request toward main memory during loading
	typedef struct packed {
		logic req;
		logic [`MEM_ADDR_W-1:0] addr;
	} load_req_t;
	// visible core state
	typedef struct packed {
		logic running;
		logic z;
		logic c;
		logic [`ADDR_W-1:0] pc;
	} core_status_t;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_LOAD, ST_CLEAR, ST_FETCH, ST_EXEC
	} core_state_t;
endpackage
`default_nettype wire

// ==== rtl/cond_eval.sv ====
// Purpose: decide whether an instruction runs from its condition code
// Assumes: z and c are the current flags
// Notes: purely combinational, one code bit per flag pair
`default_nettype none
module cond_eval (
	// condition code and flags
	input wire logic [3:0] cond,
	input wire logic z,
	input wire logic c,
	// result
	output logic pass
);
	// select the code bit addressed by {c,z}
	assign pass = cond[{c, z}];
endmodule // cond_eval
`default_nettype wire

// ==== rtl/core_fetch_operand_decode.sv ====
// Purpose: load, fetch, operand resolution, write back and conditions
// Assumes: main memory answers each held read with one load_valid pulse
// Notes: two cycles per instruction, fetch then execute
// Notes on behaviour
// - local ram holds whole 32-bit words only
// - local ram has no outside access path
// - execution starts at register 0
// - resolve, execute, then step to next
// - modified registers execute their new contents
// - destination field addresses the operated register
// - immediate source zero-extended, else register contents
// - arithmetic result written to destination register
// - immediate source limited to 0..511
// - jump target indirect unless immediate
// - always and never condition codes exist
// - equal is z set, not-equal z clear
// - above needs carry and zero clear
// - start copies 496 words, clears specials, runs
// - decrement, branch only when result nonzero
// - below is c set, above-or-same c clear
`default_nettype none
`include "core_defs.svh"
module core_fetch_operand_decode
	import core_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// start request and image base in main memory
	input wire logic start,
	input wire logic [`MEM_ADDR_W-1:0] load_base,
	// main memory read answer
	input wire logic [`WORD_W-1:0] load_data,
	input wire logic load_valid,
	// main memory read request
	output load_req_t load,
	// core state
	output core_status_t status
);

	// local register ram, word wide, no byte lanes
	logic [`WORD_W-1:0] ram [`RAM_DEPTH];
	// sequencer state
	core_state_t state;
	// load and clear index
	logic [9:0] idx;
	// current instruction
	instr_t ir;

	// assertions below sample on the clock and sleep in reset
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// alu: carry or borrow in bit 32, result below
	function automatic logic [`WORD_W:0] alu(
		input logic [5:0] op,
		input logic [`WORD_W-1:0] d,
		input logic [`WORD_W-1:0] s
	);
		logic [`WORD_W:0] r;
		r = {1'b0, d};
		unique case (op)
			`OP_ADD: r = {1'b0, d} + {1'b0, s};
			`OP_SUB: r = {1'b0, d} - {1'b0, s};
			`OP_AND: r = {1'b0, d & s};
			`OP_OR: r = {1'b0, d | s};
			`OP_XOR: r = {1'b0, d ^ s};
			`OP_MOV: r = {1'b0, s};
			default: r = {1'b0, d};
		endcase
		return r;
	endfunction

	// opcode classes
	function automatic logic is_alu(input logic [5:0] op);
		return op == `OP_ADD || op == `OP_SUB || op == `OP_AND ||
			op == `OP_OR || op == `OP_XOR || op == `OP_MOV;
	endfunction

	// operand resolution
	wire in_exec = state == ST_EXEC;
	// destination value from the addressed register
	wire [`WORD_W-1:0] dval = ram[ir.dst];
	// register contents named by the source field
	wire [`WORD_W-1:0] reg_src = ram[ir.src];
	// immediate is the field itself, zero extended
	wire [`WORD_W-1:0] imm_val = {`IMM_PAD, ir.src};
	wire [`WORD_W-1:0] sval = ir.imm ? imm_val : reg_src;

	// condition evaluation on current flags
	logic cond_pass;
	cond_eval u_cond (
		.cond(ir.cond),
		.z(status.z),
		.c(status.c),
		.pass(cond_pass)
	);

	// instruction classes and results
	wire op_alu = is_alu(ir.opcode);
	wire op_jmp = ir.opcode == `OP_JMP;
	wire op_djnz = ir.opcode == `OP_DJNZ;
	wire [`WORD_W:0] alu_out = alu(ir.opcode, dval, sval);
	wire [`WORD_W-1:0] djnz_val = dval - `WORD_ONE;
	wire [`WORD_W-1:0] exec_res = op_djnz ? djnz_val : alu_out[`WORD_W-1:0];
	wire exec_carry = op_djnz ? (dval == `WORD_ZERO) : alu_out[`WORD_W];
	// jump target, direct or indirect
	wire [`ADDR_W-1:0] target = sval[`ADDR_W-1:0];
	wire jump_taken = in_exec && cond_pass &&
		(op_jmp || (op_djnz && djnz_val != `WORD_ZERO));
	// next program counter
	wire [`ADDR_W-1:0] next_pc = jump_taken ? target
		: status.pc + `PC_STEP;

	// single ram write port, shared by load, clear and execute
	wire load_wr = state == ST_LOAD && load_valid;
	wire clear_wr = state == ST_CLEAR;
	wire exec_wr = in_exec && cond_pass &&
		(op_djnz || (op_alu && ir.wr));
	wire wr_en = load_wr || clear_wr || exec_wr;
	wire [`ADDR_W-1:0] wr_addr = exec_wr ? ir.dst : idx[`ADDR_W-1:0];
	wire [`WORD_W-1:0] wr_data = load_wr ? load_data
		: clear_wr ? `WORD_ZERO : exec_res;
	// flag updates only when the instruction runs
	wire z_upd = in_exec && cond_pass && ir.wz && !op_jmp;
	wire c_upd = in_exec && cond_pass && ir.wc && !op_jmp;
	// end of load and clear phases
	wire load_done = load_wr && idx == `LOAD_LAST;
	wire clear_done = clear_wr && idx == `CLEAR_LAST;

	// ram storage, no reset, word writes only
	always_ff @(posedge clk) begin
		if (wr_en) begin
			ram[wr_addr] <= wr_data;
		end
	end

	// sequencer, index and instruction register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			idx <= `IDX_ZERO;
			ir <= '0;
		end else if (start) begin
			// start or restart: copy the image again
			state <= ST_LOAD;
			idx <= `IDX_ZERO;
		end else begin
			unique case (state)
				// wait for start
				ST_IDLE: state <= ST_IDLE;
				// one word per answer
				ST_LOAD: begin
					if (load_wr) begin
						idx <= idx + `IDX_STEP;
					end
					if (load_done) begin
						state <= ST_CLEAR;
					end
				end
				// zero the special registers
				ST_CLEAR: begin
					idx <= idx + `IDX_STEP;
					if (clear_done) begin
						state <= ST_FETCH;
					end
				end
				// read the word at pc, fresh from ram
				ST_FETCH: begin
					ir <= ram[status.pc];
					state <= ST_EXEC;
				end
				// execute and go fetch again
				ST_EXEC: state <= ST_FETCH;
			endcase
		end
	end

	// main memory read request
	always_ff @(posedge clk) begin
		if (!resetn) begin
			load <= '0;
		end else if (start) begin
			load.req <= 1'b1;
			load.addr <= load_base;
		end else if (load_done) begin
			load.req <= 1'b0;
		end else if (load_wr) begin
			load.addr <= load.addr + `WORD_BYTES;
		end
	end

	// program counter, flags and running
	always_ff @(posedge clk) begin
		if (!resetn) begin
			status <= '0;
		end else if (start) begin
			status.running <= 1'b0;
			status.pc <= `PC_RESET;
		end else begin
			if (clear_done) begin
				status.running <= 1'b1;
				status.pc <= `PC_RESET;
			end
			if (in_exec) begin
				status.pc <= next_pc;
			end
			if (z_upd) begin
				status.z <= exec_res == `WORD_ZERO;
			end
			if (c_upd) begin
				status.c <= exec_carry;
			end
		end
	end

	// checks on the sequencer and datapath
	start_at_zero_a: assert property (
		clear_done && !start |=> state == ST_FETCH && status.pc == `PC_RESET
		&& status.running)
		else $error("fetch did not start at register zero");

	seq_advance_a: assert property (
		in_exec && !jump_taken && !start |=>
		status.pc == $past(status.pc) + `PC_STEP
		##1 (state == ST_EXEC || $past(start)))
		else $error("pc did not step to next register");

	skip_no_write_a: assert property (
		in_exec && !cond_pass && !start |-> !wr_en ##1
		$stable(status.z) && $stable(status.c))
		else $error("skipped instruction changed state");

	add_writeback_a: assert property (
		in_exec && cond_pass && ir.opcode == `OP_ADD && ir.wr |->
		wr_en && wr_addr == ir.dst && wr_data == dval + sval)
		else $error("add result not written to destination");

	imm_source_a: assert property (
		in_exec && ir.imm |-> sval == {`IMM_PAD, ir.src}
		&& sval[`WORD_W-1:`ADDR_W] == `IMM_PAD)
		else $error("immediate source not zero extended");

	reg_source_a: assert property (
		in_exec && !ir.imm |-> sval == ram[ir.src])
		else $error("register source value wrong");

	indirect_jump_a: assert property (
		in_exec && op_jmp && cond_pass && !ir.imm && !start |=>
		status.pc == $past(reg_src[`ADDR_W-1:0]))
		else $error("indirect jump target wrong");

	direct_jump_a: assert property (
		in_exec && op_jmp && cond_pass && ir.imm && !start |=>
		status.pc == $past(ir.src))
		else $error("direct jump target wrong");

	djnz_zero_a: assert property (
		in_exec && op_djnz && dval == `WORD_ONE && !start |=>
		status.pc == $past(status.pc) + `PC_STEP)
		else $error("decrement to zero still branched");

	never_cond_a: assert property (
		in_exec && ir.cond == `COND_NEVER |-> !cond_pass && !exec_wr)
		else $error("never condition executed");

	zero_conds_a: assert property (
		(ir.cond == `COND_EQUAL |-> cond_pass == status.z) and
		(ir.cond == `COND_ZERO_CLEAR |-> cond_pass == !status.z))
		else $error("equal condition wrong");

	above_cond_a: assert property (
		ir.cond == `COND_ABOVE |->
		cond_pass == (!status.c && !status.z))
		else $error("above condition wrong");

	carry_conds_a: assert property (
		(ir.cond == `COND_BELOW |-> cond_pass == status.c) and
		(ir.cond == `COND_ABOVE_OR_SAME |-> cond_pass == !status.c))
		else $error("carry condition wrong");

	load_word_a: assert property (
		load_wr && !start |-> wr_en && wr_addr == idx[`ADDR_W-1:0]
		&& load.req ##1 load.addr == $past(load.addr) + `WORD_BYTES
		|| !load.req)
		else $error("loaded word misplaced");

	clear_zero_a: assert property (
		clear_wr |-> wr_en && wr_data == `WORD_ZERO && idx > `LOAD_LAST)
		else $error("special register not cleared");

	// main scenarios
	load_done_c: cover property (@(posedge clk) disable iff (!resetn)
		clear_done ##1 state == ST_FETCH);
	djnz_loop_c: cover property (@(posedge clk) disable iff (!resetn)
		in_exec && op_djnz && jump_taken);
	skipped_c: cover property (@(posedge clk) disable iff (!resetn)
		in_exec && !cond_pass);
	self_mod_c: cover property (@(posedge clk) disable iff (!resetn)
		exec_wr && wr_addr == status.pc + `PC_STEP);
	logic_op_c: cover property (@(posedge clk) disable iff (!resetn)
		in_exec && cond_pass && ir.opcode == `OP_XOR);

endmodule // core_fetch_operand_decode
`default_nettype wire

// ==== dv/core_fetch_operand_decode_tb.sv ====
// Purpose: self-checking bench for load, fetch, operands and conditions
// Assumes: two cycles per instruction once running, pc and flags settle
// Notes: program image is built from encoded words at time zero
`default_nettype none
`include "core_defs.svh"
module core_fetch_operand_decode_tb
	import core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus and observed signals
	logic clk;
	logic resetn;
	logic start;
	logic [`MEM_ADDR_W-1:0] load_base;
	logic [`WORD_W-1:0] load_data;
	logic load_valid;
	load_req_t load;
	core_status_t status;
	// image in main memory and bookkeeping
	logic [`WORD_W-1:0] prog [0:495];
	int err_total;
	int check_count;
	// flag groups {wz,wc,wr,imm}
	localparam logic [3:0] W_IMM = 4'h3;
	localparam logic [3:0] W_REG = 4'h2;
	localparam logic [3:0] ZCW_I = 4'hf;
	localparam logic [3:0] ZCW_R = 4'he;
	localparam logic [3:0] J_IMM = 4'h1;

	core_fetch_operand_decode dut_u (
		.clk(clk),
		.resetn(resetn),
		.start(start),
		.load_base(load_base),
		.load_data(load_data),
		.load_valid(load_valid),
		.load(load),
		.status(status)
	);

	// free running clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// one instruction word from its fields
	function automatic logic [31:0] mk(input logic [5:0] op,
		input logic [3:0] fl, input logic [3:0] cd,
		input logic [8:0] d, input logic [8:0] s);
		return {op, fl, cd, d, s};
	endfunction

	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// verdict and end of run
	task automatic give_verdict();
		if (err_total == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one instruction: fetch and exec, then pc and flags
	task automatic step(input logic [8:0] pc, input logic z, input logic c);
		repeat (2) @(posedge clk);
		#1;
		check({21'h0, status.pc, status.z, status.c}, {21'h0, pc, z, c});
	endtask

	// reset values of all outputs
	task automatic reset_check();
		check({15'h0, load}, 32'h0);
		check({20'h0, status}, 32'h0);
	endtask

	// copy the image word by word, addresses stepping by a word
	task automatic load_image(input logic [15:0] base);
		int n;
		load_base = base;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		for (int i = 0; i < 496; i++) begin
			load_data = prog[i];
			load_valid = 1'b1;
			check({16'h0, load.addr}, {16'h0, base + 16'(4 * i)});
			check({31'h0, load.req}, 32'h1);
			@(posedge clk);
			#1;
		end
		load_valid = 1'b0;
		check({31'h0, load.req}, 32'h0);
		n = 0;
		while (status.running !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 40) begin
			err_total++;
			give_verdict();
		end
		check({23'h0, status.pc}, 32'h0);
	endtask

	// walk the program through flow, operands and conditions
	task automatic run_program();
		step(9'd1, 1'b1, 1'b0);
		step(9'd2, 1'b1, 1'b0);
		step(9'd4, 1'b1, 1'b0);
		step(9'd5, 1'b0, 1'b0);
		step(9'd6, 1'b0, 1'b1);
		step(9'd9, 1'b0, 1'b1);
		step(9'd10, 1'b0, 1'b1);
		step(9'd11, 1'b0, 1'b1);
		step(9'd12, 1'b0, 1'b1);
		step(9'd20, 1'b0, 1'b1);
		step(9'd20, 1'b0, 1'b1);
		step(9'd21, 1'b0, 1'b1);
		step(9'd22, 1'b1, 1'b0);
		step(9'd23, 1'b1, 1'b0);
		step(9'd30, 1'b1, 1'b0);
		step(9'd31, 1'b0, 1'b0);
		step(9'd32, 1'b0, 1'b0);
		step(9'd33, 1'b1, 1'b0);
		step(9'd33, 1'b1, 1'b0);
	endtask

	// restart while running drops running and reloads
	task automatic restart_abort();
		load_base = 16'h0100;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		check({31'h0, status.running}, 32'h0);
		check({15'h0, load}, {15'h0, 1'b1, 16'h0100});
		check({23'h0, status.pc}, 32'h0);
		check({30'h0, status.z, status.c}, 32'h2);
	endtask

	// main sequence
	initial begin
		resetn = 1'b0;
		start = 1'b0;
		load_base = 16'h0;
		load_data = 32'h0;
		load_valid = 1'b0;
		err_total = 0;
		check_count = 0;
		for (int i = 0; i < 496; i++) begin
			prog[i] = 32'h0;
		end
		prog[0] = mk(`OP_MOV, ZCW_I, `COND_ALWAYS, 9'd200, 9'd0);
		prog[1] = mk(`OP_JMP, J_IMM, `COND_ZERO_CLEAR, 9'd0, 9'd5);
		prog[2] = mk(`OP_JMP, J_IMM, `COND_EQUAL, 9'd0, 9'd4);
		prog[4] = mk(`OP_ADD, ZCW_I, `COND_ALWAYS, 9'd201, 9'd511);
		prog[5] = mk(`OP_SUB, ZCW_I, `COND_ALWAYS, 9'd202, 9'd1);
		prog[6] = mk(`OP_JMP, J_IMM, `COND_BELOW, 9'd0, 9'd9);
		prog[9] = mk(`OP_JMP, J_IMM, `COND_ABOVE_OR_SAME, 9'd0, 9'd3);
		prog[10] = mk(`OP_JMP, J_IMM, `COND_ABOVE, 9'd0, 9'd3);
		prog[11] = mk(`OP_ADD, ZCW_I, `COND_NEVER, 9'd202, 9'd1);
		prog[12] = mk(`OP_JMP, 4'h0, `COND_ALWAYS, 9'd0, 9'd205);
		prog[20] = mk(`OP_DJNZ, W_IMM, `COND_ALWAYS, 9'd206, 9'd20);
		prog[21] = mk(`OP_SUB, ZCW_R, `COND_ALWAYS, 9'd201, 9'd207);
		prog[22] = mk(`OP_MOV, W_REG, `COND_ALWAYS, 9'd23, 9'd208);
		prog[23] = mk(`OP_JMP, J_IMM, `COND_NEVER, 9'd0, 9'd3);
		prog[30] = mk(`OP_AND, ZCW_I, `COND_ALWAYS, 9'd209, 9'h0f0);
		prog[31] = mk(`OP_OR, ZCW_I, `COND_ALWAYS, 9'd209, 9'h00f);
		prog[32] = mk(`OP_XOR, ZCW_I, `COND_ALWAYS, 9'd209, 9'h03f);
		prog[33] = mk(`OP_JMP, J_IMM, `COND_ALWAYS, 9'd0, 9'd33);
		// data words
		prog[201] = 32'h00000001;
		prog[205] = 32'h00000014;
		prog[206] = 32'h00000002;
		prog[207] = 32'h00000200;
		prog[208] = mk(`OP_JMP, J_IMM, `COND_ALWAYS, 9'd0, 9'd30);
		prog[209] = 32'h00000f30;
		repeat (5) @(posedge clk);
		#1;
		reset_check();
		resetn = 1'b1;
		@(posedge clk);
		#1;
		load_image(16'h2000);
		run_program();
		restart_abort();
		give_verdict();
	end
endmodule // core_fetch_operand_decode_tb
`default_nettype wire
